// file: design/bms_regs.svh
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH
// flash geometry, byte addresses relative to the array base
`define BMS_FLASH_BASE 32'h0008_0000
`define BMS_ARRAY_BYTES 32'h0001_0000
`define BMS_USER_BYTES 32'h0000_f800
`define BMS_ADDR_W 16
// boot marker word, absolute and offset form
`define BMS_MARKER_ADDR 32'h0008_0014
`define BMS_MARKER_OFS 16'h0014
`define BMS_MARKER_ERASED 32'hffff_ffff
`define BMS_ERASED_BYTE 8'hff
// page size for erase
`define BMS_PAGE_BYTES 16'h0200
`define BMS_PAGE_SHIFT 9
// calibration words copied at power-on
`define BMS_CAL_WORDS 4
`define BMS_CAL_OFS 16'hf800
`endif

// file: design/bms_pkg.sv
package bms_pkg;
  typedef enum logic [5:0] {
    BMS_IDLE = 6'h01,
    BMS_MARK = 6'h02,
    BMS_CAL = 6'h04,
    BMS_RUN = 6'h08,
    BMS_PROG = 6'h10,
    BMS_ERASE = 6'h20
  } bms_state_t;
  typedef enum logic [1:0] {
    BMS_MODE_NONE = 2'h0,
    BMS_MODE_USER = 2'h1,
    BMS_MODE_DL = 2'h2
  } bms_mode_t;
  typedef enum logic [1:0] {
    BMS_OP_READ = 2'h0,
    BMS_OP_PROG = 2'h1,
    BMS_OP_ERASE = 2'h2
  } bms_op_t;
endpackage

// file: design/bms_sync_if.sv
`timescale 1ns/10ps
interface bms_sync_if;
  logic raw;
  logic level;
  logic valid;
  modport src (output raw, input level, input valid);
  modport dst (input raw, output level, output valid);
endinterface

// file: design/bms_pin_sync.sv
`timescale 1ns/10ps
module bms_pin_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  bms_sync_if.dst s
);
  import bms_pkg::*;
  logic [2:0] sh_ff;
  logic [2:0] nxt_sh;
  logic level_ff;
  logic nxt_level;
  logic valid_ff;
  logic nxt_valid;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  always_comb begin
    nxt_sh = {sh_ff[1:0], s.raw};
    nxt_level = level_ff;
    nxt_cnt = cnt_ff;
    // stage two and three must agree; stage one feeds only stage two
    if (sh_ff[1] == sh_ff[2]) begin
      nxt_level = sh_ff[2];
    end
    if (cnt_ff != 2'h3) begin
      nxt_cnt = cnt_ff + 2'h1;
    end
    nxt_valid = (cnt_ff == 2'h3) && (sh_ff[1] == sh_ff[2]);
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sh_ff <= 3'h0;
      level_ff <= 1'b0;
      cnt_ff <= 2'h0;
      valid_ff <= 1'b0;
    end else begin
      sh_ff <= nxt_sh;
      level_ff <= nxt_level;
      cnt_ff <= nxt_cnt;
      valid_ff <= nxt_valid;
    end
  end
  assign s.level = level_ff;
  assign s.valid = valid_ff;
endmodule

// file: design/bms_boot_select.sv
`timescale 1ns/10ps
`include "bms_regs.svh"
// Function
// (R1) download mode only if boot pin low and marker word reads all ones
// (R2) in download mode, I2C host may program the whole 62 kB user region
// (R3) 64 kB array: lower 62 kB user, upper 2 kB embedded firmware
// (R4) user accesses never see the 2 kB firmware region
// (R5) calibration coefficients copied to peripherals before user code runs; the last cal_we pulse comes in the first cycle of user_run
// (R6) byte program only into erased bytes; erase by whole pages
// (R7) three shared port lines go to JTAG only while boot pin high
// (R8) user code must not drive shared debug lines while debugging
// (R9) leave marker word erased so a blocked part can recover via I2C
// (R10) pin and marker sampled once at reset release; mode held
module bms_boot_select #(
  parameter int CAL_WORDS = `BMS_CAL_WORDS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic port0_line0_shared_boot,
  // flash array port, read latency ended by fl_done, word-wide read data, byte-wide write data
  output logic fl_req,
  output bms_pkg::bms_op_t fl_op,
  output logic [15:0] fl_addr,
  output logic [7:0] fl_wdata,
  input wire logic [31:0] fl_rdata,
  input wire logic fl_done,
  // user access path (core or I2C download host)
  input wire logic usr_req,
  input wire bms_pkg::bms_op_t usr_op,
  input wire logic [15:0] usr_addr,
  input wire logic [7:0] usr_wdata,
  output logic usr_ack,
  output logic usr_err,
  output logic [31:0] usr_rdata,
  // calibration delivery
  output logic cal_we,
  output logic [1:0] cal_sel,
  output logic [31:0] cal_data,
  // mode outputs
  output bms_pkg::bms_mode_t boot_mode,
  output logic dl_mode,
  output logic user_run,
  output logic jtag_sel,
  output logic i2c_dl_en
);
  import bms_pkg::*;

  bms_sync_if bm_s();
  bms_pin_sync u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .s(bm_s)
  );
  assign bm_s.raw = port0_line0_shared_boot;

  function automatic logic is_user(input logic [15:0] a);
    is_user = ({16'h0, a} < `BMS_USER_BYTES); // R3
  endfunction

  function automatic logic [15:0] page_base(input logic [15:0] a);
    page_base = a & ~(`BMS_PAGE_BYTES - 16'h1);
  endfunction

  bms_state_t st_ff, nxt_st;
  bms_mode_t mode_ff, nxt_mode;
  logic pin_ff, nxt_pin;
  logic [1:0] cal_ff, nxt_cal;
  logic wait_ff, nxt_wait;
  logic [15:0] addr_ff, nxt_addr;
  logic [7:0] wd_ff, nxt_wd;
  logic ack_ff, nxt_ack;
  logic err_ff, nxt_err;
  logic [31:0] rd_ff, nxt_rd;
  logic cwe_ff, nxt_cwe;
  logic [31:0] cd_ff, nxt_cd;
  logic [1:0] csel_ff, nxt_csel;
  logic [1:0] bsel;

  // byte lane of the word under the current address
  assign bsel = addr_ff[1:0];

  always_comb begin
    nxt_st = st_ff;
    nxt_mode = mode_ff;
    nxt_pin = pin_ff;
    nxt_cal = cal_ff;
    nxt_wait = wait_ff;
    nxt_addr = addr_ff;
    nxt_wd = wd_ff;
    nxt_ack = 1'b0;
    nxt_err = 1'b0;
    nxt_rd = rd_ff;
    nxt_cwe = 1'b0;
    nxt_cd = cd_ff;
    nxt_csel = csel_ff;
    fl_req = 1'b0;
    fl_op = BMS_OP_READ;
    fl_addr = addr_ff;
    fl_wdata = wd_ff;
    unique case (st_ff)
      BMS_IDLE: begin
        // sample the settled pin exactly once after release
        if (bm_s.valid) begin
          nxt_pin = bm_s.level; // R10
          nxt_st = BMS_MARK;
        end
      end
      BMS_MARK: begin
        fl_req = 1'b1;
        fl_addr = `BMS_MARKER_OFS;
        if (fl_done) begin
          // calibration always loads first, whatever the mode
          nxt_st = BMS_CAL; // R5
          nxt_cal = 2'h0;
          if (!pin_ff && fl_rdata == `BMS_MARKER_ERASED) begin
            nxt_mode = BMS_MODE_DL; // R1
          end else begin
            nxt_mode = BMS_MODE_USER; // R1
          end
        end
      end
      BMS_CAL: begin
        fl_req = 1'b1;
        fl_addr = `BMS_CAL_OFS + {cal_ff, 2'h0};
        if (fl_done) begin
          nxt_cwe = 1'b1; // R5
          nxt_cd = fl_rdata;
          nxt_csel = cal_ff;
          nxt_cal = cal_ff + 2'h1;
          if (32'(cal_ff) == CAL_WORDS - 1) begin
            nxt_st = BMS_RUN;
          end
        end
      end
      BMS_RUN: begin
        if (usr_req && !ack_ff && !err_ff) begin
          nxt_addr = usr_addr;
          nxt_wd = usr_wdata;
          if (!is_user(usr_addr)) begin
            nxt_err = 1'b1; // R4
            nxt_rd = 32'h0; // R4
          end else if (usr_op == BMS_OP_ERASE) begin
            nxt_addr = page_base(usr_addr); // R6
            nxt_st = BMS_ERASE;
          end else if (usr_op == BMS_OP_PROG) begin
            nxt_st = BMS_PROG; // R2
            nxt_wait = 1'b0;
          end else begin
            nxt_st = BMS_PROG;
            nxt_wait = 1'b1;
          end
        end
      end
      BMS_PROG: begin
        // phase 0 reads the byte back for the erased check, phase 1 serves a user read
        fl_req = 1'b1;
        fl_addr = {addr_ff[15:2], 2'h0};
        if (wait_ff && fl_op == BMS_OP_READ && fl_done && nxt_wd == wd_ff
            && usr_op == BMS_OP_READ) begin
          nxt_rd = fl_rdata;
          nxt_ack = 1'b1;
          nxt_st = BMS_RUN;
        end else if (!wait_ff && fl_done) begin
          // programming can only clear bits of an erased byte
          if (fl_rdata[8*bsel +: 8] != `BMS_ERASED_BYTE) begin
            nxt_err = 1'b1; // R6
            nxt_st = BMS_RUN;
          end else begin
            nxt_wait = 1'b1;
            nxt_st = BMS_ERASE;
            nxt_cal = 2'h3;
          end
        end
      end
      BMS_ERASE: begin
        fl_req = 1'b1;
        if (cal_ff == 2'h3) begin
          fl_op = BMS_OP_PROG; // R6
          fl_addr = addr_ff;
        end else begin
          fl_op = BMS_OP_ERASE; // R6
          fl_addr = addr_ff;
        end
        if (fl_done) begin
          nxt_ack = 1'b1;
          nxt_cal = 2'h0;
          nxt_st = BMS_RUN;
        end
      end
      default: begin
        nxt_st = BMS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_ff <= BMS_IDLE;
      mode_ff <= BMS_MODE_NONE;
      pin_ff <= 1'b0;
      cal_ff <= 2'h0;
      wait_ff <= 1'b0;
      addr_ff <= 16'h0;
      wd_ff <= 8'h0;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      rd_ff <= 32'h0;
      cwe_ff <= 1'b0;
      cd_ff <= 32'h0;
      csel_ff <= 2'h0;
    end else begin
      st_ff <= nxt_st;
      mode_ff <= nxt_mode;
      pin_ff <= nxt_pin;
      cal_ff <= nxt_cal;
      wait_ff <= nxt_wait;
      addr_ff <= nxt_addr;
      wd_ff <= nxt_wd;
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
      rd_ff <= nxt_rd;
      cwe_ff <= nxt_cwe;
      cd_ff <= nxt_cd;
      csel_ff <= nxt_csel;
    end
  end

  assign usr_ack = ack_ff;
  assign usr_err = err_ff;
  assign usr_rdata = rd_ff;
  assign cal_we = cwe_ff;
  assign cal_sel = csel_ff;
  assign cal_data = cd_ff;
  assign boot_mode = mode_ff;
  assign dl_mode = (mode_ff == BMS_MODE_DL);
  assign i2c_dl_en = (mode_ff == BMS_MODE_DL) && (st_ff != BMS_CAL); // R2
  assign user_run = (mode_ff == BMS_MODE_USER) && (st_ff != BMS_CAL) &&
    (st_ff != BMS_MARK); // R5
  // latched pin, so a stray toggle by user code cannot drop the debugger
  assign jtag_sel = pin_ff && (mode_ff != BMS_MODE_NONE); // R7
endmodule

// file: bench/bms_flash_model.sv
`timescale 1ns/10ps
module bms_flash_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic fl_req,
  input wire bms_pkg::bms_op_t fl_op,
  input wire logic [15:0] fl_addr,
  input wire logic [7:0] fl_wdata,
  input wire logic [3:0] lat,
  output logic [31:0] fl_rdata,
  output logic fl_done
);
  import bms_pkg::*;
  logic [7:0] mem [0:65535];
  logic [3:0] cnt = 4'h0;
  logic [15:0] a;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
    fl_done = 1'b0;
    fl_rdata = 32'h0;
  end
  always @(posedge mclk) begin
    fl_done <= 1'b0;
    // read data is only good with done; scramble it otherwise
    fl_rdata <= ~fl_rdata;
    a = {fl_addr[15:2], 2'h0};
    if (sys_rst || !fl_req || fl_done) begin
      cnt <= 4'h0;
    end else if (cnt != lat) begin
      cnt <= cnt + 4'h1;
    end else begin
      cnt <= 4'h0;
      fl_done <= 1'b1;
      fl_rdata <= {mem[a+16'h3], mem[a+16'h2], mem[a+16'h1], mem[a]};
      // cells only lose bits: a byte not erased gets corrupted
      if (fl_op == BMS_OP_PROG) mem[fl_addr] = mem[fl_addr] & fl_wdata;
      if (fl_op == BMS_OP_ERASE) begin
        for (int i = 0; i < 512; i++) mem[{fl_addr[15:9], 9'h0} + i] = 8'hff;
      end
    end
  end
endmodule

// file: bench/bms_boot_select_chk.sv
`timescale 1ns/10ps
module bms_boot_select_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic fl_req,
  input wire bms_pkg::bms_op_t fl_op,
  input wire logic [15:0] fl_addr,
  input wire logic usr_req,
  input wire bms_pkg::bms_op_t usr_op,
  input wire logic [15:0] usr_addr,
  input wire logic usr_ack,
  input wire logic usr_err,
  input wire logic [31:0] usr_rdata,
  input wire bms_pkg::bms_mode_t boot_mode,
  input wire logic dl_mode,
  input wire logic user_run,
  input wire logic jtag_sel,
  input wire logic i2c_dl_en
);
  import bms_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire tk = usr_req && !usr_ack && !usr_err && (user_run || i2c_dl_en);
  property p_dl; dl_mode == (boot_mode == BMS_MODE_DL); endproperty
  property p_hold; boot_mode != BMS_MODE_NONE |=> $stable(boot_mode); endproperty
  property p_jt; jtag_sel |-> boot_mode == BMS_MODE_USER ##1 jtag_sel; endproperty
  property p_hid; tk && usr_addr >= 16'hf800 |=> usr_err && !usr_rdata; endproperty
  property p_fl; fl_req && fl_op != BMS_OP_READ |-> fl_addr < 16'hf800; endproperty
  // fl_req low while tk means the block is idle and takes the request now
  property p_pr;
    tk && !fl_req && usr_op == BMS_OP_PROG |=> usr_err || fl_req;
  endproperty
  property p_run; user_run |-> boot_mode == BMS_MODE_USER; endproperty
  property p_den; i2c_dl_en |-> dl_mode && !user_run; endproperty
  a_dl: assert property (p_dl) else $error("bad dl_mode");
  a_hold: assert property (p_hold) else $error("mode moved");
  a_jt: assert property (p_jt) else $error("bad jtag_sel");
  a_hid: assert property (p_hid) else $error("hidden seen");
  a_fl: assert property (p_fl) else $error("fw region hit");
  a_pr: assert property (p_pr) else $error("no flash op");
  a_run: assert property (p_run) else $error("bad user_run");
  a_den: assert property (p_den) else $error("bad dl_en");
  c_dl: cover property (i2c_dl_en);
  c_jt: cover property (jtag_sel);
  c_err: cover property (usr_err);
endmodule
bind bms_boot_select bms_boot_select_chk u_chk (.mclk(mclk),
  .sys_rst(sys_rst), .fl_req(fl_req), .fl_op(fl_op), .fl_addr(fl_addr),
  .usr_req(usr_req), .usr_op(usr_op), .usr_addr(usr_addr),
  .usr_ack(usr_ack), .usr_err(usr_err), .usr_rdata(usr_rdata),
  .boot_mode(boot_mode), .dl_mode(dl_mode), .user_run(user_run),
  .jtag_sel(jtag_sel), .i2c_dl_en(i2c_dl_en));

// file: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import bms_pkg::*;
  logic mclk, sys_rst, pin, fl_req, fl_done, usr_req, usr_ack, usr_err;
  logic cal_we, dl_mode, user_run, jtag_sel, i2c_dl_en, got_err;
  logic [15:0] fl_addr, usr_addr;
  logic [7:0] fl_wdata, usr_wdata;
  logic [31:0] fl_rdata, usr_rdata, cal_data, got_rd;
  logic [1:0] cal_sel;
  logic [3:0] lat;
  bms_op_t fl_op, usr_op;
  bms_mode_t boot_mode;
  int error_cnt, n_tests, n_cal;
  bms_boot_select dut (.mclk(mclk), .sys_rst(sys_rst),
    .port0_line0_shared_boot(pin), .fl_req(fl_req), .fl_op(fl_op),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rdata(fl_rdata),
    .fl_done(fl_done), .usr_req(usr_req), .usr_op(usr_op),
    .usr_addr(usr_addr), .usr_wdata(usr_wdata), .usr_ack(usr_ack),
    .usr_err(usr_err), .usr_rdata(usr_rdata), .cal_we(cal_we),
    .cal_sel(cal_sel), .cal_data(cal_data), .boot_mode(boot_mode),
    .dl_mode(dl_mode), .user_run(user_run), .jtag_sel(jtag_sel),
    .i2c_dl_en(i2c_dl_en));
  bms_flash_model fm (.mclk(mclk), .sys_rst(sys_rst), .fl_req(fl_req),
    .fl_op(fl_op), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .lat(lat),
    .fl_rdata(fl_rdata), .fl_done(fl_done));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task complete_run;
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task tmo(input int i);
    if (i >= 300) begin
      error_cnt++;
      complete_run();
    end
  endtask
  always @(negedge mclk) begin
    if (cal_we === 1'b1) begin
      n_cal++;
      check(cal_data, {16'hca11, 14'h0, cal_sel});
    end
  end
  task xfer(input bms_op_t op, input logic [15:0] ad, input logic [7:0] wd);
    int i;
    usr_op = op;
    usr_addr = ad;
    usr_wdata = wd;
    usr_req = 1'b1;
    for (i = 0; i < 300 && !(usr_ack || usr_err); i++) @(negedge mclk);
    tmo(i);
    usr_req = 1'b0;
    got_err = usr_err;
    got_rd = usr_rdata;
    @(negedge mclk);
  endtask
  task t_boot(input logic p, input logic [7:0] mk, input bms_mode_t m);
    int i;
    sys_rst = 1'b1;
    pin = p;
    n_cal = 0;
    // let the model's erased fill at time zero finish before preloading
    @(negedge mclk);
    for (i = 0; i < 16; i++) fm.mem[16'hf800 + i] = 8'(i[1:0] == 0 ?
      i / 4 : i[1:0] == 2 ? 8'h11 : i[1:0] == 3 ? 8'hca : 8'h0);
    fm.mem[16'h14] = mk;
    repeat (11) @(negedge mclk);
    sys_rst = 1'b0;
    for (i = 0; i < 300 && !(user_run || i2c_dl_en); i++) @(negedge mclk);
    tmo(i);
    check(32'(boot_mode), 32'(m));
    check(32'(dl_mode), 32'(m == BMS_MODE_DL));
    check(32'(jtag_sel), 32'(p));
    // only the boot line moves; the shared debug lines are never driven
    pin = ~p;
    repeat (20) @(negedge mclk);
    // counted late so the last calibration pulse is surely in
    check(32'(n_cal), 32'h4);
    check(32'(boot_mode), 32'(m));
    check(32'(jtag_sel), 32'(p));
  endtask
  task t_prog;
    xfer(BMS_OP_PROG, 16'h1001, 8'h5a);
    check(32'(got_err), 32'h0);
    xfer(BMS_OP_READ, 16'h1002, 8'h0);
    check(got_rd, 32'hffff5aff);
    xfer(BMS_OP_PROG, 16'h1001, 8'h0f);
    check(32'(got_err), 32'h1);
    xfer(BMS_OP_PROG, 16'hf7ff, 8'h33);
    xfer(BMS_OP_READ, 16'hf7fc, 8'h0);
    check(got_rd, 32'h33ffffff);
  endtask
  task t_erase;
    xfer(BMS_OP_PROG, 16'h0fff, 8'h12);
    xfer(BMS_OP_ERASE, 16'h1000, 8'h0);
    check(32'(got_err), 32'h0);
    xfer(BMS_OP_READ, 16'h1000, 8'h0);
    check(got_rd, 32'hffffffff);
    xfer(BMS_OP_READ, 16'h0ffc, 8'h0);
    check(got_rd, 32'h12ffffff);
  endtask
  task t_hidden;
    xfer(BMS_OP_READ, 16'hf800, 8'h0);
    check({got_err, got_rd[30:0]}, 32'h80000000);
    xfer(BMS_OP_PROG, 16'hfffc, 8'h0);
    check(32'(got_err), 32'h1);
    check(32'(fm.mem[16'hfffc]), 32'hff);
  endtask
  initial begin
    {sys_rst, pin, usr_req, usr_addr, usr_wdata, lat} = '0;
    usr_op = BMS_OP_READ;
    sys_rst = 1'b1;
    t_boot(1'b0, 8'hff, BMS_MODE_DL);
    t_prog();
    t_erase();
    t_hidden();
    lat = 4'h3;
    t_boot(1'b0, 8'h00, BMS_MODE_USER);
    t_hidden();
    t_boot(1'b1, 8'hff, BMS_MODE_USER);
    t_erase();
    complete_run();
  end
endmodule
